/* File: hdl/lrc_consts.svh */
// Register offsets, field positions, reset values and codes for the linear regulator control
`ifndef LRC_CONSTS_SVH
`define LRC_CONSTS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define LRC_OFS_CTRL      12'h000
`define LRC_OFS_VOLT      12'h004
`define LRC_OFS_STATUS    12'h008

// -----------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------
`define LRC_CTRL_RUN_ON_BIT     0
`define LRC_CTRL_STBY_ON_BIT    1
`define LRC_CTRL_LIMIT_ON_BIT   2
`define LRC_CTRL_BRINGUP_BIT    3
`define LRC_CTRL_WIDTH          4

// -----------------------------------------------------------------
// Voltage register fields
// -----------------------------------------------------------------
`define LRC_VOLT_RUN_LSB        0
`define LRC_VOLT_STBY_LSB       8
`define LRC_VCODE_W             4

// -----------------------------------------------------------------
// Status register fields
// -----------------------------------------------------------------
`define LRC_ST_ENABLED_BIT      0
`define LRC_ST_SWITCH_BIT       1
`define LRC_ST_PULLDN_BIT       2
`define LRC_ST_LIMIT_BIT        3
`define LRC_ST_BRINGUP_PD_BIT   4
`define LRC_ST_STANDBY_BIT      5
`define LRC_ST_VCODE_LSB        8
`define LRC_ST_MV_LSB           16

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define LRC_CTRL_RESET          4'h0
`define LRC_VCODE_RESET         4'h0

`endif

/* File: hdl/lrc_pkg.sv */
// Types shared by the linear regulator control design
package lrc_pkg;

   // Operating mode of the output stage
   typedef enum logic [1:0]
   {
      LRC_OUT_OFF,
      LRC_OUT_REGULATE,
      LRC_OUT_SWITCH
   } lrc_out_mode_e;

   typedef logic [3:0]  lrc_vcode_t;
   typedef logic [15:0] lrc_mv_t;

endpackage

/* File: hdl/lrc_volt_table.sv */
// Voltage code to output millivolt lookup
`timescale 1ns/1ps

module lrc_volt_table
(
   // Code in
   input  wire lrc_pkg::lrc_vcode_t code_in,
   // Target voltage out
   output lrc_pkg::lrc_mv_t         mv_out
);

   // -----------------------------------------------------------------
   // Set point table, monotonic but not evenly spaced
   // -----------------------------------------------------------------
   always_comb
   begin
      case (code_in)
         4'h0:    mv_out = 16'h05DC; // 1.5 V
         4'h1:    mv_out = 16'h0640; // 1.6 V
         4'h2:    mv_out = 16'h0708; // 1.8 V
         4'h3:    mv_out = 16'h073A; // 1.85 V
         4'h4:    mv_out = 16'h0866; // 2.15 V
         4'h5:    mv_out = 16'h09C4; // 2.5 V
         4'h6:    mv_out = 16'h0AF0; // 2.8 V
         4'h7:    mv_out = 16'h0BB8; // 3.0 V
         4'h8:    mv_out = 16'h0C1C; // 3.1 V
         4'h9:    mv_out = 16'h0C4E; // 3.15 V
         4'hA:    mv_out = 16'h0C80; // 3.2 V
         4'hB:    mv_out = 16'h0CE4; // 3.3 V
         4'hC:    mv_out = 16'h0D16; // 3.35 V
         4'hD:    mv_out = 16'h0FA0; // 4.0 V
         4'hE:    mv_out = 16'h1324; // 4.9 V
         default: mv_out = 16'h1388; // 5.0 V
      endcase
   end

endmodule

/* File: hdl/lrc_top.sv */
// Linear regulator control: APB registers, mode selection and output stage control
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "lrc_consts.svh"

module lrc_top
(
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // System state and fused settings (pins from the power-state logic)
   input  wire logic        standby_mode_in,
   input  wire logic        quiet_powered_off_state_in,
   input  wire logic        power_up_load_in,
   input  wire logic        in_power_up_seq_in,
   input  wire logic        fused_switch_mode_sel_in,
   input  wire logic [3:0]  fused_voltage_default_in,
   // Output stage controls
   output logic             linear_reg_enable_out,
   output logic             regulate_on_out,
   output logic             switch_on_out,
   output logic             pull_down_on_out,
   output logic             switch_limit_active_out,
   output logic             bringup_pull_down_out,
   output lrc_pkg::lrc_vcode_t voltage_code_out,
   output lrc_pkg::lrc_mv_t    target_mv_out
);

   // -----------------------------------------------------------------
   // Input synchronisers for the system-state pins
   // -----------------------------------------------------------------
   localparam int SYNC_W = 9;

   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic              standby_s;
   logic              qpo_s;
   logic              pu_load_s;
   logic              in_seq_s;
   logic              fused_ls_s;
   logic [3:0]        fused_v_s;

   // Two stages each; only the second stage feeds logic
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end
      else
      begin
         sync1_reg <= {fused_voltage_default_in, fused_switch_mode_sel_in, in_power_up_seq_in,
                       power_up_load_in, quiet_powered_off_state_in, standby_mode_in};
         sync2_reg <= sync1_reg;
      end
   end

   assign standby_s  = sync2_reg[0];
   assign qpo_s      = sync2_reg[1];
   assign pu_load_s  = sync2_reg[2];
   assign in_seq_s   = sync2_reg[3];
   assign fused_ls_s = sync2_reg[4];
   assign fused_v_s  = sync2_reg[8:5];

   // Rising edge of the power-up load strobe, so a long strobe loads once
   logic pu_load_d_reg;
   logic pu_load_pulse;

   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
         pu_load_d_reg <= 1'b0;
      else
         pu_load_d_reg <= pu_load_s;
   end

   assign pu_load_pulse = pu_load_s & ~pu_load_d_reg;

   // -----------------------------------------------------------------
   // APB access decode
   // -----------------------------------------------------------------
   logic apb_wr;
   logic apb_rd;
   logic hit_ctrl;
   logic hit_volt;
   logic hit_status;

   assign apb_wr     = psel_in & penable_in & pwrite_in;
   assign apb_rd     = psel_in & penable_in & ~pwrite_in;

   // Address decode as an if chain
   always_comb
   begin
      hit_ctrl   = 1'b0;
      hit_volt   = 1'b0;
      hit_status = 1'b0;
      if (paddr_in == `LRC_OFS_CTRL)
         hit_ctrl = 1'b1;
      else if (paddr_in == `LRC_OFS_VOLT)
         hit_volt = 1'b1;
      else if (paddr_in == `LRC_OFS_STATUS)
         hit_status = 1'b1;
   end

   // -----------------------------------------------------------------
   // Control register: enables, switch current limit, bring-up mode
   // -----------------------------------------------------------------
   logic [`LRC_CTRL_WIDTH-1:0] ctrl_reg;

   // Power-up load wins over a software write in the same cycle
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
         ctrl_reg <= `LRC_CTRL_RESET;
      else if (pu_load_pulse)
      begin
         ctrl_reg[`LRC_CTRL_RUN_ON_BIT]  <= in_seq_s;
         ctrl_reg[`LRC_CTRL_STBY_ON_BIT] <= in_seq_s;
      end
      else if (apb_wr && hit_ctrl && pstrb_in[0])
         ctrl_reg <= pwdata_in[`LRC_CTRL_WIDTH-1:0];
   end

   // -----------------------------------------------------------------
   // Voltage register: run and standby codes
   // -----------------------------------------------------------------
   lrc_pkg::lrc_vcode_t run_voltage_code_reg;
   lrc_pkg::lrc_vcode_t standby_voltage_code_reg;

   // Byte lanes let software change one code without touching the other
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         run_voltage_code_reg     <= `LRC_VCODE_RESET;
         standby_voltage_code_reg <= `LRC_VCODE_RESET;
      end
      else if (pu_load_pulse)
      begin
         run_voltage_code_reg     <= fused_v_s;
         standby_voltage_code_reg <= fused_v_s;
      end
      else if (apb_wr && hit_volt)
      begin
         if (pstrb_in[0])
            run_voltage_code_reg <= pwdata_in[`LRC_VOLT_RUN_LSB +: `LRC_VCODE_W];
         if (pstrb_in[1])
            standby_voltage_code_reg <= pwdata_in[`LRC_VOLT_STBY_LSB +: `LRC_VCODE_W];
      end
   end

   // -----------------------------------------------------------------
   // Mode selection and output stage decision
   // -----------------------------------------------------------------
   logic                  active_on;
   lrc_pkg::lrc_vcode_t   active_code;
   lrc_pkg::lrc_out_mode_e out_mode;
   lrc_pkg::lrc_mv_t      table_mv;

   // Follows the synchronised mode pin each cycle, so a mode change swaps both
   assign active_on   = standby_s ? ctrl_reg[`LRC_CTRL_STBY_ON_BIT]
                                  : ctrl_reg[`LRC_CTRL_RUN_ON_BIT];
   assign active_code = standby_s ? standby_voltage_code_reg
                                  : run_voltage_code_reg;

   // Off wins over the fused mode bit
   always_comb
   begin
      if (!active_on)
         out_mode = lrc_pkg::LRC_OUT_OFF;
      else if (fused_ls_s)
         out_mode = lrc_pkg::LRC_OUT_SWITCH;
      else
         out_mode = lrc_pkg::LRC_OUT_REGULATE;
   end

   lrc_volt_table u_volt_table
   (
      .code_in (active_code),
      .mv_out  (table_mv)
   );

   // -----------------------------------------------------------------
   // Registered output stage controls
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         linear_reg_enable_out   <= 1'b0;
         regulate_on_out         <= 1'b0;
         switch_on_out           <= 1'b0;
         pull_down_on_out        <= 1'b1;
         switch_limit_active_out <= 1'b0;
         bringup_pull_down_out   <= 1'b0;
         voltage_code_out        <= `LRC_VCODE_RESET;
         target_mv_out           <= '0;
      end
      else
      begin
         linear_reg_enable_out   <= (out_mode != lrc_pkg::LRC_OUT_OFF);
         regulate_on_out         <= (out_mode == lrc_pkg::LRC_OUT_REGULATE);
         switch_on_out           <= (out_mode == lrc_pkg::LRC_OUT_SWITCH);
         pull_down_on_out        <= (out_mode == lrc_pkg::LRC_OUT_OFF);
         switch_limit_active_out <= (out_mode == lrc_pkg::LRC_OUT_SWITCH)
                                    & ctrl_reg[`LRC_CTRL_LIMIT_ON_BIT];
         bringup_pull_down_out   <= ctrl_reg[`LRC_CTRL_BRINGUP_BIT] & qpo_s;
         voltage_code_out        <= active_code;
         target_mv_out           <= table_mv;
      end
   end

   // -----------------------------------------------------------------
   // APB read data and answer, zero wait states
   // -----------------------------------------------------------------
   logic [31:0] rd_word;

   // Status shows the live output stage state; unmapped reads give zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (hit_ctrl)
         rd_word[`LRC_CTRL_WIDTH-1:0] = ctrl_reg;
      else if (hit_volt)
      begin
         rd_word[`LRC_VOLT_RUN_LSB +: `LRC_VCODE_W]  = run_voltage_code_reg;
         rd_word[`LRC_VOLT_STBY_LSB +: `LRC_VCODE_W] = standby_voltage_code_reg;
      end
      else if (hit_status)
      begin
         rd_word[`LRC_ST_ENABLED_BIT]    = linear_reg_enable_out;
         rd_word[`LRC_ST_SWITCH_BIT]     = switch_on_out;
         rd_word[`LRC_ST_PULLDN_BIT]     = pull_down_on_out;
         rd_word[`LRC_ST_LIMIT_BIT]      = switch_limit_active_out;
         rd_word[`LRC_ST_BRINGUP_PD_BIT] = bringup_pull_down_out;
         rd_word[`LRC_ST_STANDBY_BIT]    = standby_s;
         rd_word[`LRC_ST_VCODE_LSB +: `LRC_VCODE_W] = voltage_code_out;
         rd_word[`LRC_ST_MV_LSB +: 16]   = target_mv_out;
      end
   end

   // Answer in the first access cycle; pready is registered so it is
   // high in the cycle after setup, which is the access phase
   always_ff @(posedge clk_sys_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end
      else
      begin
         pready_out  <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & ~(hit_ctrl | hit_volt | hit_status);
         prdata_out  <= (psel_in & ~penable_in & ~pwrite_in) ? rd_word : 32'h0000_0000;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   sequence s_enable_low;
      !active_on;
   endsequence

   sequence s_off_stage;
      !linear_reg_enable_out && pull_down_on_out && !switch_on_out && !regulate_on_out;
   endsequence

   chk_run_off_kept: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (!standby_s && !ctrl_reg[`LRC_CTRL_RUN_ON_BIT]) |=> !linear_reg_enable_out)
      else $error("regulator enabled in Run mode with run enable low");

   chk_stby_off_kept: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (standby_s && !ctrl_reg[`LRC_CTRL_STBY_ON_BIT]) |=> !linear_reg_enable_out)
      else $error("regulator enabled in Standby mode with standby enable low");

   chk_pu_enable_load: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      pu_load_pulse |=> (ctrl_reg[`LRC_CTRL_RUN_ON_BIT] == $past(in_seq_s)
                         && ctrl_reg[`LRC_CTRL_STBY_ON_BIT] == $past(in_seq_s)))
      else $error("enable bits not loaded by power-up sequence");

   chk_off_pulldown: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      s_enable_low |=> s_off_stage)
      else $error("pull-down not on while disabled");

   chk_mode_by_fuse: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      active_on |=> (switch_on_out == $past(fused_ls_s)) && (regulate_on_out != switch_on_out))
      else $error("wrong output stage mode for fused bit");

   chk_code_by_mode: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      1'b1 |=> voltage_code_out == ($past(standby_s) ? $past(standby_voltage_code_reg)
                                                     : $past(run_voltage_code_reg)))
      else $error("voltage code not from the active mode field");

   chk_pu_volt_load: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      pu_load_pulse |=> (run_voltage_code_reg == $past(fused_v_s)
                         && standby_voltage_code_reg == $past(fused_v_s)))
      else $error("voltage fields not loaded from fused default");

   chk_table_ends: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (active_code == 4'hF) |=> target_mv_out == 16'h1388)
      else $error("top code does not give 5.0 V");

   chk_limit_gate: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      switch_limit_active_out |-> switch_on_out && $past(ctrl_reg[`LRC_CTRL_LIMIT_ON_BIT]))
      else $error("current limit active outside switch mode or without enable");

   chk_bringup_pd: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
      (ctrl_reg[`LRC_CTRL_BRINGUP_BIT] && qpo_s) |=> bringup_pull_down_out)
      else $error("bring-up pull-down missing in quiet powered-off state");

endmodule

/* File: sim/testbench.sv */
// Self-checking testbench for the linear regulator control block
`timescale 1ns/1ps
`include "lrc_consts.svh"

`define LRC_TB_CHK(name, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         $display("unexpected %s expected %0h seen %0h", name, exp, got); \
         error_cnt++; \
      end \
   end

module testbench;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                clk_sys_in;
   logic                nrst_in;
   logic                psel_in;
   logic                penable_in;
   logic                pwrite_in;
   logic [11:0]         paddr_in;
   logic [31:0]         pwdata_in;
   logic [3:0]          pstrb_in;
   logic [31:0]         prdata_out;
   logic                pready_out;
   logic                pslverr_out;
   logic                standby_mode_in;
   logic                quiet_powered_off_state_in;
   logic                power_up_load_in;
   logic                in_power_up_seq_in;
   logic                fused_switch_mode_sel_in;
   logic [3:0]          fused_voltage_default_in;
   logic                linear_reg_enable_out;
   logic                regulate_on_out;
   logic                switch_on_out;
   logic                pull_down_on_out;
   logic                switch_limit_active_out;
   logic                bringup_pull_down_out;
   lrc_pkg::lrc_vcode_t voltage_code_out;
   lrc_pkg::lrc_mv_t    target_mv_out;
   int                  error_cnt;
   int                  samples_checked;
   integer              seed;
   logic [3:0]          m_ctrl;
   logic [3:0]          m_run;
   logic [3:0]          m_stby;
   logic [31:0]         rd;
   logic                er;

   lrc_top u_dut
   (
      .clk_sys_in                 (clk_sys_in),
      .nrst_in                    (nrst_in),
      .psel_in                    (psel_in),
      .penable_in                 (penable_in),
      .pwrite_in                  (pwrite_in),
      .paddr_in                   (paddr_in),
      .pwdata_in                  (pwdata_in),
      .pstrb_in                   (pstrb_in),
      .prdata_out                 (prdata_out),
      .pready_out                 (pready_out),
      .pslverr_out                (pslverr_out),
      .standby_mode_in            (standby_mode_in),
      .quiet_powered_off_state_in (quiet_powered_off_state_in),
      .power_up_load_in           (power_up_load_in),
      .in_power_up_seq_in         (in_power_up_seq_in),
      .fused_switch_mode_sel_in   (fused_switch_mode_sel_in),
      .fused_voltage_default_in   (fused_voltage_default_in),
      .linear_reg_enable_out      (linear_reg_enable_out),
      .regulate_on_out            (regulate_on_out),
      .switch_on_out              (switch_on_out),
      .pull_down_on_out           (pull_down_on_out),
      .switch_limit_active_out    (switch_limit_active_out),
      .bringup_pull_down_out      (bringup_pull_down_out),
      .voltage_code_out           (voltage_code_out),
      .target_mv_out              (target_mv_out)
   );

   // Free-running system clock, 10 ns period
   initial
   begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // ------------------------------------------------------------
   // Expectation functions
   // ------------------------------------------------------------
   // Millivolts for each output code, written out rather than computed
   function automatic logic [15:0] mv_of(input logic [3:0] c);
      logic [15:0] t [16];
      t = '{16'h05DC, 16'h0640, 16'h0708, 16'h073A, 16'h0866, 16'h09C4, 16'h0AF0, 16'h0BB8,
            16'h0C1C, 16'h0C4E, 16'h0C80, 16'h0CE4, 16'h0D16, 16'h0FA0, 16'h1324, 16'h1388};
      return t[c];
   endfunction

   // Status word expected from the model state and the settled pins
   function automatic logic [31:0] exp_status();
      logic       en;
      logic       fs;
      logic [3:0] c;
      en = standby_mode_in ? m_ctrl[1] : m_ctrl[0];
      c  = standby_mode_in ? m_stby : m_run;
      fs = fused_switch_mode_sel_in;
      return {mv_of(c), 4'h0, c, 2'h0, standby_mode_in, m_ctrl[3] & quiet_powered_off_state_in,
              en & fs & m_ctrl[2], ~en, en & fs, en};
   endfunction

   // ------------------------------------------------------------
   // Bus and check tasks
   // ------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One APB transfer; request held until pready is seen at a rising edge
   task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                           input logic [3:0] st, output logic [31:0] rdata, output logic err);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= wr;
      paddr_in   <= a;
      pwdata_in  <= wd;
      pstrb_in   <= st;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      do
      begin
         @(posedge clk_sys_in);
         n++;
      end
      while (pready_out !== 1'b1 && n < 20);
      rdata = prdata_out;
      err   = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      if (n >= 20)
      begin
         $display("unexpected pready expected 1 seen timeout");
         error_cnt++;
         final_report();
      end
   endtask

   // Register write that also updates the bench's own copy of the registers
   task automatic reg_write(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      logic        e;
      apb_xfer(1'b1, a, wd, st, r, e);
      `LRC_TB_CHK("write error", (a > `LRC_OFS_STATUS), e)
      if (a == `LRC_OFS_CTRL && st[0])
         m_ctrl = wd[3:0];
      if (a == `LRC_OFS_VOLT && st[0])
         m_run = wd[3:0];
      if (a == `LRC_OFS_VOLT && st[1])
         m_stby = wd[11:8];
   endtask

   // Let pins cross the synchroniser, then compare every output stage control and register
   task automatic check_all(input string tname);
      logic [31:0] s;
      logic [31:0] r;
      logic        e;
      repeat (4) @(posedge clk_sys_in);
      #1;
      s = exp_status();
      `LRC_TB_CHK("enable", s[0], linear_reg_enable_out)
      `LRC_TB_CHK("regulate", s[0] & ~fused_switch_mode_sel_in, regulate_on_out)
      `LRC_TB_CHK("switch", s[1], switch_on_out)
      `LRC_TB_CHK("pull down", s[2], pull_down_on_out)
      `LRC_TB_CHK("limit", s[3], switch_limit_active_out)
      `LRC_TB_CHK("bringup pd", s[4], bringup_pull_down_out)
      `LRC_TB_CHK("code", s[11:8], voltage_code_out)
      `LRC_TB_CHK("millivolts", s[31:16], target_mv_out)
      apb_xfer(1'b0, `LRC_OFS_STATUS, 32'h0, 4'h0, r, e);
      `LRC_TB_CHK("status", s, r & 32'hFFFF0F3F)
      apb_xfer(1'b0, `LRC_OFS_CTRL, 32'h0, 4'h0, r, e);
      `LRC_TB_CHK("ctrl", {28'h0, m_ctrl}, r & 32'h0000000F)
      apb_xfer(1'b0, `LRC_OFS_VOLT, 32'h0, 4'h0, r, e);
      `LRC_TB_CHK("volt", {20'h0, m_stby, 4'h0, m_run}, r & 32'h00000F0F)
      $display("test %s done", tname);
   endtask

   // Power-up load: settings settle through the sync first, then a strobe
   task automatic power_up(input logic in_seq, input logic [3:0] code);
      @(posedge clk_sys_in);
      in_power_up_seq_in       <= in_seq;
      fused_voltage_default_in <= code;
      repeat (4) @(posedge clk_sys_in);
      power_up_load_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      power_up_load_in <= 1'b0;
      m_ctrl[1:0] = {in_seq, in_seq};
      m_run       = code;
      m_stby      = code;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      seed = 32'hB1C135E0;
      {nrst_in, psel_in, penable_in, pwrite_in, power_up_load_in} = 5'h0;
      {paddr_in, pwdata_in, pstrb_in} = '0;
      {standby_mode_in, quiet_powered_off_state_in, in_power_up_seq_in} = 3'h0;
      fused_switch_mode_sel_in = 1'b0;
      fused_voltage_default_in = 4'h0;
      {error_cnt, samples_checked} = '0;
      {m_ctrl, m_run, m_stby} = 12'h000;
      repeat (6) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      check_all("reset defaults");
      power_up(1'b0, 4'h9);
      check_all("load outside sequence");
      power_up(1'b1, 4'hE);
      check_all("load inside sequence");
      // Every code in both modes, other mode's code kept different
      for (int i = 0; i < 32; i++)
      begin
         @(posedge clk_sys_in);
         standby_mode_in <= i[4];
         reg_write(`LRC_OFS_VOLT, {20'h0, i[3:0], 4'h0, ~i[3:0]} ^ {20'h0, 8'h0F * i[4], 4'h0},
                   4'hF);
         check_all("code table");
      end
      // Lane strobes: only the standby lane is written
      reg_write(`LRC_OFS_VOLT, 32'h00000A05, 4'h2);
      check_all("byte lane");
      // Unmapped places and the read-only status register
      apb_xfer(1'b0, 12'h00C, 32'h0, 4'h0, rd, er);
      `LRC_TB_CHK("unmapped read error", 1'b1, er)
      `LRC_TB_CHK("unmapped read data", 32'h0, rd)
      reg_write(12'h010, 32'hFFFFFFFF, 4'hF);
      reg_write(`LRC_OFS_CTRL, 32'hFFFFFFFF, 4'hE);
      reg_write(`LRC_OFS_STATUS, 32'hFFFFFFFF, 4'hF);
      check_all("refused writes");
      // Random settings and pins, mode flips between checks
      for (int i = 0; i < 60; i++)
      begin
         reg_write(`LRC_OFS_CTRL, $random(seed), 4'hF);
         reg_write(`LRC_OFS_VOLT, $random(seed), 4'hF);
         @(posedge clk_sys_in);
         {standby_mode_in, quiet_powered_off_state_in, fused_switch_mode_sel_in} <=
            3'($random(seed));
         check_all("random");
      end
      // Mid-run reset: enables and codes fall back to 0 until the next load
      @(posedge clk_sys_in);
      nrst_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      {m_ctrl, m_run, m_stby} = 12'h000;
      check_all("mid-run reset");
      power_up(1'b1, 4'h3);
      check_all("reload after reset");
      final_report();
   end

endmodule
